// >>> dcops_exec.v
// execute block for decrement_file_op, invert_register_op and
// decrement_skip_on_null_op of an 8-bit core
// assumes one instruction per ref_clk cycle, presented with instr_valid, and a
// file register read port that returns data combinationally for instr addr
//
// Function
// [RULE_01] decrement_file_op puts f-1 in acc if d is 0, else back in f.
// [RULE_02] invert_register_op puts ~f in acc if d is 0, else back in f.
// [RULE_03] decrement_skip_on_null_op routes f-1 by d and keeps all flags.
// [RULE_04] decrement_skip_on_null_op skips only when its result is zero.
// [RULE_05] a skip drops the fetched next word for a nop, taking two cycles.
// [RULE_06] decrement and invert: one cycle, zero_flag = (result == 0).
`include "dcops_regs.vh"
module dcops_exec
(
   // clock and reset
   input wire ref_clk,
   input wire rstn,
   // instruction stream
   input wire instr_valid,
   input wire [13:0] instr,
   // file register read port
   output wire [6:0] file_addr,
   input wire [7:0] file_rdata,
   // file register write port
   output reg file_we,
   output reg [6:0] file_waddr,
   output reg [7:0] file_wdata,
   // accumulator and status
   output reg [7:0] acc,
   output reg zero_flag,
   // sequencing
   output reg discard_next,
   output wire busy,
   output reg done
);
   // sequencer states
   localparam ST_RUN = 1'b0;
   localparam ST_NOP = 1'b1;
   // operation kinds after decode
   localparam OP_NONE = 2'h0;
   localparam OP_DEC = 2'h1;
   localparam OP_INV = 2'h2;
   localparam OP_SKIP = 2'h3;

   // sequencer
   reg state;
   reg next_state;
   // decode
   reg [1:0] op_kind;
   wire [5:0] opc;
   wire dest;
   wire is_dec;
   wire is_inv;
   wire is_skip;
   wire slot_free;
   wire hit;
   wire skip_taken;
   // result unit
   wire [7:0] result;
   wire res_zero;
   // next values of the registered outputs
   reg next_file_we;
   reg [6:0] next_waddr;
   reg [7:0] next_wdata;
   reg [7:0] next_acc;
   reg next_zero_flag;
   reg next_discard;
   reg next_done;

   // instruction fields: six opcode bits, then d, then the address
   assign opc = instr[`DCOPS_OPC_HI:`DCOPS_OPC_LO];
   assign dest = instr[`DCOPS_DEST_BIT];
   assign file_addr = instr[`DCOPS_ADDR_HI:`DCOPS_ADDR_LO];

   // opcode decode; every other encoding is left to the rest of the core
   always @*
   begin
      op_kind = OP_NONE;
      case (opc)
         `DCOPS_OP_DEC:
            op_kind = OP_DEC; // RULE_01
         `DCOPS_OP_INV:
            op_kind = OP_INV; // RULE_02
         `DCOPS_OP_DECSKIP:
            op_kind = OP_SKIP; // RULE_03
         default:
            op_kind = OP_NONE;
      endcase
   end

   // one-hot view of the decoded kind
   assign is_dec = (op_kind == OP_DEC);
   assign is_inv = (op_kind == OP_INV);
   assign is_skip = (op_kind == OP_SKIP);

   // in the nop slot the fetched word is thrown away, so nothing executes
   assign slot_free = (state == ST_RUN);
   assign hit = instr_valid & slot_free & (is_dec | is_inv | is_skip);
   // only a zero result of the skip form costs the extra cycle
   assign skip_taken = hit & is_skip & res_zero; // RULE_04
   assign busy = (state == ST_NOP);

   // one shared unit; the skip form reuses the decrement path
   dcops_alu u_alu
   (
      .operand(file_rdata),
      .invert(is_inv),
      .result(result),
      .is_zero(res_zero)
   );

   // skip sequencer: one extra cycle that executes a no-operation
   always @*
   begin
      next_state = ST_RUN;
      case (state)
         ST_RUN:
         begin
            if (skip_taken)
               next_state = ST_NOP; // RULE_04
         end
         ST_NOP:
            next_state = ST_RUN; // RULE_05
         default:
            next_state = ST_RUN;
      endcase
   end

   // sequencer state register
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         state <= ST_RUN;
      else
         state <= next_state;
   end

   // write port: one-cycle pulse, only when d selects the register
   always @*
   begin
      next_file_we = 1'b0;
      next_waddr = file_waddr;
      next_wdata = file_wdata;
      if (hit)
      begin
         next_file_we = dest; // RULE_01
         next_waddr = file_addr;
         next_wdata = result;
      end
   end

   // accumulator takes the result when d is clear, for all three ops
   always @*
   begin
      next_acc = acc;
      if (hit & ~dest)
         next_acc = result; // RULE_02
   end

   // zero flag: the skip form must leave status alone
   always @*
   begin
      next_zero_flag = zero_flag;
      if (hit & ~is_skip) // RULE_03
         next_zero_flag = res_zero; // RULE_06
   end

   // strobes; done follows the last cycle of each instruction
   always @*
   begin
      next_discard = skip_taken; // RULE_05
      next_done = (hit & ~skip_taken) | busy; // RULE_06
   end

   // write port registers; waddr and wdata load on every executed op, d set or not, and hold otherwise
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         file_we <= 1'b0;
         file_waddr <= `DCOPS_WADDR_RST;
         file_wdata <= `DCOPS_WDATA_RST;
      end
      else
      begin
         file_we <= next_file_we;
         file_waddr <= next_waddr;
         file_wdata <= next_wdata;
      end
   end

   // accumulator register
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         acc <= `DCOPS_ACC_RST;
      else
         acc <= next_acc;
   end

   // zero flag register, held across the skip form
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         zero_flag <= `DCOPS_ZERO_RST;
      else
         zero_flag <= next_zero_flag;
   end

   // sequencing strobe registers, one cycle each
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         discard_next <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         discard_next <= next_discard;
         done <= next_done;
      end
   end
endmodule // dcops_exec

// >>> dcops_regs.vh
// constants for the decrement / complement / decrement-skip execute block
// assumes a 14-bit instruction word and an 8-bit data path
`ifndef DCOPS_REGS_VH
`define DCOPS_REGS_VH
// opcode field, instruction bits 13:8 with the destination bit removed
`define DCOPS_OPC_HI 13
`define DCOPS_OPC_LO 8
`define DCOPS_DEST_BIT 7
`define DCOPS_ADDR_HI 6
`define DCOPS_ADDR_LO 0
// upper six bits of the instruction word; d sits just below them
`define DCOPS_OP_DEC 6'h03
`define DCOPS_OP_INV 6'h09
`define DCOPS_OP_DECSKIP 6'h0b
// reset values
`define DCOPS_ZERO_RST 1'b0
`define DCOPS_ACC_RST 8'h00
`define DCOPS_WADDR_RST 7'h00
`define DCOPS_WDATA_RST 8'h00
// instruction cycles
`define DCOPS_CYC_PERIOD_NS 8
`define DCOPS_SKIP_CYCLES 2
`endif

// >>> dcops_alu.v
// result unit: decrement or bitwise invert of one 8-bit operand
// assumes a purely combinational use by the execute block
module dcops_alu
(
   // operand and selection
   input wire [7:0] operand,
   input wire invert,
   // result
   output wire [7:0] result,
   output wire is_zero
);
   // wraparound on 8'h00 is intended, as in the core alu
   assign result = invert ? ~operand : operand - 8'h01;
   assign is_zero = (result == 8'h00);
endmodule // dcops_alu

// >>> dcops_checker.sv
// execute block assertions
// assumes a bind onto dcops_exec
module dcops_checker
(
   // watched ports
   input wire ref_clk, rstn, instr_valid, file_we, busy, done,
   input wire discard_next, zero_flag,
   input wire [13:0] instr,
   input wire [6:0] file_addr, file_waddr,
   input wire [7:0] file_rdata, file_wdata, acc
);
   timeunit 1ns / 100ps;
   // taken ops; zr means a zero result
   wire tk = instr_valid && !busy;
   wire dec = tk && instr[13:8] == 6'h03;
   wire inv = tk && instr[13:8] == 6'h09;
   wire skp = tk && instr[13:8] == 6'h0b;
   wire zr = inv ? &file_rdata : file_rdata == 8'h01;
   wire dst = instr[7];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_DEC: assert property (dec && !instr[7] |=>
      acc == $past(file_rdata) - 8'h01) else $error("dec");
   AST_INV: assert property (inv && instr[7] |=>
      file_we && file_wdata == ~$past(file_rdata)) else $error("inv");
   AST_FLAG: assert property (skp |=> $stable(zero_flag))
      else $error("flag");
   AST_SKIP: assert property (skp |=> discard_next == $past(zr))
      else $error("skip");
   AST_NOP: assert property (discard_next |->
      busy ##1 done && !busy) else $error("nop");
   AST_ZERO: assert property (dec || inv |=>
      done && zero_flag == $past(zr)) else $error("zero");
   AST_ADDR: assert property (file_addr == instr[6:0])
      else $error("addr");
   AST_WPORT: assert property (dec || inv || skp |=>
      file_we == $past(dst) && file_waddr == $past(file_addr))
      else $error("wport");
   AST_SKACC: assert property (skp && !dst |=>
      acc == $past(file_rdata) - 8'h01) else $error("skip acc");
   cover property (skp ##1 discard_next);
   cover property (inv ##1 file_we);
   cover property (dec ##1 zero_flag);
endmodule // dcops_checker
bind dcops_exec dcops_checker chk (.ref_clk, .rstn, .instr_valid, .file_we,
   .busy, .done, .discard_next, .zero_flag, .instr, .file_rdata,
   .file_wdata, .acc, .file_addr, .file_waddr);

// >>> dcops_tb.sv
// self-checking bench for dcops_exec
// assumes file reads answer in the same cycle
module tb;
   timeunit 1ns / 100ps;
   reg ref_clk = 0, rstn = 0, instr_valid = 0, zm = 0;
   reg [13:0] instr = 0;
   reg [7:0] file_rdata = 0, wd, res;
   reg [9:0] e, q[$];
   reg [5:0] ops[3] = '{6'h03, 6'h09, 6'h0b};
   wire file_we, zero_flag, busy, done, discard_next;
   wire [7:0] file_wdata, acc;
   int err_total = 0, n_checks = 0;
   dcops_exec uut (.ref_clk, .rstn, .instr_valid, .instr, .file_addr(),
      .file_rdata, .file_we, .file_waddr(), .file_wdata, .acc, .zero_flag,
      .discard_next, .busy, .done);
   task chk(input [8:0] s, x);
      n_checks++;
      err_total += s !== x;
      if (s !== x) $display("CHECK FAILED %0t bad result", $time);
   endtask
   task final_report;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one op; a zero skip also offers a junk op in the slot it eats
   task op(input [5:0] o, input d, input [7:0] r);
      if (r < 8'h40) r = o == 6'h09 ? 8'hff : 8'h01;
      res = o == 6'h09 ? ~r : r - 8'h01;
      @(posedge ref_clk) #1 instr_valid = 1;
      instr = {o, d, 7'($urandom)};
      file_rdata = r;
      if (o != 6'h0b) zm = res == 0;
      q.push_back({d, res, zm});
      if (o == 6'h0b && !res) @(posedge ref_clk) #1 instr = 14'h0300;
   endtask
   // write data kept, since a skip reports done a cycle later
   always @(posedge ref_clk)
   begin
      if (file_we) wd = file_wdata;
      e = done && q.size() ? q.pop_front() : 'x;
      if (done) chk({e[9] ? wd : acc, zero_flag}, e[8:0]);
   end
   initial forever #4 ref_clk = ~ref_clk;
   // watchdog
   initial
   begin
      #20000 err_total++;
      final_report;
   end
   initial
   begin
      void'($urandom(32'h4230));
      repeat (16) @(posedge ref_clk);
      #1 rstn = 1;
      repeat (90) op(ops[$urandom % 3], 1'($urandom), 8'($urandom));
      @(posedge ref_clk) #1 instr_valid = 0;
      repeat (4) @(posedge ref_clk);
      chk(9'(q.size()), 0);
      $display("random op mix done");
      final_report;
   end
endmodule // tb
